// ===== ifsr_periph_model.sv
`timescale 1ns/1ps
// Stands in for the peripherals: turns a bench command into one-cycle request pulses
module ifsr_periph_model
    import ifsr_pkg::*;
(
    input  wire logic      mclk_i,  // System clock
    input  wire logic      rst_i,   // Async reset, active high
    input  wire ifsr_req_t fire_i,  // Sources to pulse next cycle
    output ifsr_req_t      req_o    // Request pulses to the flags
);
    // Registered, so each pulse follows fire_i one cycle later and lasts as long as fire_i is held
    always_ff @(posedge mclk_i or posedge rst_i) begin
        if (rst_i) begin
            req_o <= '0;
        end else begin
            req_o <= fire_i;
        end
    end
endmodule : ifsr_periph_model

// ===== ifsr_pkg.sv
package ifsr_pkg;

    // Register word offsets (byte addresses)
    localparam logic [11:0] IFSR_OFS_FLAGS_ZERO = 12'h000;
    localparam logic [11:0] IFSR_OFS_FLAGS_ONE  = 12'h004;
    localparam logic [11:0] IFSR_OFS_MASK_ZERO  = 12'h008;
    localparam logic [11:0] IFSR_OFS_MASK_ONE   = 12'h00c;
    localparam logic [11:0] IFSR_OFS_CLR_ZERO   = 12'h010;
    localparam logic [11:0] IFSR_OFS_CLR_ONE    = 12'h014;

    // Reset values
    localparam logic [15:0] IFSR_FLAGS_RST = 16'h0000;
    localparam logic [15:0] IFSR_MASK_RST  = 16'h0000;
    localparam logic [31:0] IFSR_RDATA_RST = 32'h0000_0000;

    // Implemented bit maps; small variants lose the second serial port, fourth timer, third unit
    localparam logic [15:0] IFSR_IMPL_ZERO       = 16'hb9cd;
    localparam logic [15:0] IFSR_IMPL_ONE_LARGE  = 16'hea1f;
    localparam logic [15:0] IFSR_IMPL_ONE_SMALL  = 16'h201f;

    // Flag positions in register zero
    localparam int IFSR_B0_NVM_OP   = 15;
    localparam int IFSR_B0_ADC_DONE = 13;
    localparam int IFSR_B0_SER_A_TX = 12;
    localparam int IFSR_B0_SER_A_RX = 11;
    localparam int IFSR_B0_TIMER_C  = 8;
    localparam int IFSR_B0_TIMER_B  = 7;
    localparam int IFSR_B0_CAPCMP_B = 6;
    localparam int IFSR_B0_TIMER_A  = 3;
    localparam int IFSR_B0_CAPCMP_A = 2;
    localparam int IFSR_B0_EXT_ZERO = 0;

    // Flag positions in register one
    localparam int IFSR_B1_SER_B_TX = 15;
    localparam int IFSR_B1_SER_B_RX = 14;
    localparam int IFSR_B1_EXT_TWO  = 13;
    localparam int IFSR_B1_TIMER_D  = 11;
    localparam int IFSR_B1_CAPCMP_C = 9;
    localparam int IFSR_B1_EXT_ONE  = 4;
    localparam int IFSR_B1_PIN_CHG  = 3;
    localparam int IFSR_B1_COMPARE  = 2;
    localparam int IFSR_B1_SYNC_COL = 1;
    localparam int IFSR_B1_SYNC_EVT = 0;

    // AHB-Lite encodings
    localparam logic [1:0] IFSR_HTRANS_NONSEQ = 2'h2;
    localparam logic [1:0] IFSR_HTRANS_SEQ    = 2'h3;
    localparam logic       IFSR_HRESP_OKAY    = 1'h0;

    // One-cycle request pulses from the peripherals, same clock domain
    typedef struct packed {
        logic nvm_op;
        logic adc_done;
        logic serial_a_tx;
        logic serial_a_rx;
        logic timer_c;
        logic timer_b;
        logic capcmp_b;
        logic timer_a;
        logic capcmp_a;
        logic ext_pin_zero;
        logic serial_b_tx;
        logic serial_b_rx;
        logic ext_pin_two;
        logic timer_d;
        logic capcmp_c;
        logic ext_pin_one;
        logic pin_change;
        logic comparator;
        logic sync_port_a_collision;
        logic sync_port_a_event;
    } ifsr_req_t;

    // Write kinds held from address phase to data phase
    typedef enum logic [2:0] {
        IFSR_WR_NONE  = 3'b000,
        IFSR_WR_FLG0  = 3'b001,
        IFSR_WR_FLG1  = 3'b010,
        IFSR_WR_MSK0  = 3'b011,
        IFSR_WR_MSK1  = 3'b100,
        IFSR_WR_CLR0  = 3'b101,
        IFSR_WR_CLR1  = 3'b110
    } ifsr_wr_t;

    typedef struct packed {
        logic [15:0] flags_zero;
        logic [15:0] flags_one;
        logic [15:0] mask_zero;
        logic [15:0] mask_one;
        ifsr_wr_t    wr_kind;
        logic [31:0] hrdata;
        logic        irq;
    } ifsr_state_t;

endpackage : ifsr_pkg

// ===== ifsr_top.sv
`timescale 1ns/1ps
// Contract
// - A flag reads 1 once its source requested an interrupt, else 0.
// - All implemented flags are software readable and writable, zero after reset.
// - Unimplemented positions of both flag registers always read zero.
// - Register zero bit 15 latches the memory operation request.
// - Register zero bit 13 latches the conversion complete request.
// - Register zero bits 12 and 11 hold serial port A transmit and receive.
// - Register zero bits 8, 7, 3 hold timers C, B and A.
// - Register zero bits 6 and 2 hold capture/compare units B and A.
// - Register zero bit 0 latches external pin zero.
// - Register one bits 15 and 14 hold serial port B transmit and receive.
// - Register one bit 13 holds external pin two, bit 4 pin one.
// - Register one bit 11 holds timer D, bit 9 capture/compare unit C.
// - Register one bit 3 holds pin change, bit 2 comparator.
// - Register one bit 1 holds sync port collision, bit 0 its event.
// - Small variants leave serial B, timer D and unit C flags unimplemented.
// - Flag order follows the sources' natural vector order.
module ifsr_top
    import ifsr_pkg::*;
#(
    parameter bit LARGE_VARIANT = 1'b1,  // Full part with second serial port
    parameter int ADDR_W        = 12     // Decoded address width
) (
    input  wire logic              mclk_i,       // System clock, 100 MHz
    input  wire logic              rst_i,        // Async reset, active high
    input  wire logic              hsel_i,       // Slave select
    input  wire logic [ADDR_W-1:0] haddr_i,      // Byte address
    input  wire logic [1:0]        htrans_i,     // Transfer type
    input  wire logic              hwrite_i,     // Write when high
    input  wire logic [2:0]        hsize_i,      // Transfer size
    input  wire logic [31:0]       hwdata_i,     // Write data
    input  wire logic              hready_i,     // Bus ready
    input  wire ifsr_req_t         req_i,        // Request pulses
    output logic [31:0]            hrdata_o,     // Read data
    output logic                   hreadyout_o,  // Slave ready
    output logic                   hresp_o,      // Response, always OKAY
    output logic [15:0]            flags_zero_o, // Flags to enable stage
    output logic [15:0]            flags_one_o,  // Flags to enable stage
    output logic                   irq_o         // Level interrupt
);

    localparam logic [15:0] IMPL_ONE = LARGE_VARIANT ? IFSR_IMPL_ONE_LARGE : IFSR_IMPL_ONE_SMALL;

    ifsr_state_t st_q;
    ifsr_state_t st_d;
    logic [15:0] set_zero;
    logic [15:0] set_one;
    logic        access;
    logic [11:0] addr_ofs;

    // Scatter request pulses to their flag positions, in vector order
    always_comb begin
        set_zero = 16'h0000;
        set_one  = 16'h0000;
        set_zero[IFSR_B0_NVM_OP]   = req_i.nvm_op;
        set_zero[IFSR_B0_ADC_DONE] = req_i.adc_done;
        set_zero[IFSR_B0_SER_A_TX] = req_i.serial_a_tx;
        set_zero[IFSR_B0_SER_A_RX] = req_i.serial_a_rx;
        set_zero[IFSR_B0_TIMER_C]  = req_i.timer_c;
        set_zero[IFSR_B0_TIMER_B]  = req_i.timer_b;
        set_zero[IFSR_B0_CAPCMP_B] = req_i.capcmp_b;
        set_zero[IFSR_B0_TIMER_A]  = req_i.timer_a;
        set_zero[IFSR_B0_CAPCMP_A] = req_i.capcmp_a;
        set_zero[IFSR_B0_EXT_ZERO] = req_i.ext_pin_zero;
        set_one[IFSR_B1_SER_B_TX]  = req_i.serial_b_tx;
        set_one[IFSR_B1_SER_B_RX]  = req_i.serial_b_rx;
        set_one[IFSR_B1_EXT_TWO]   = req_i.ext_pin_two;
        set_one[IFSR_B1_TIMER_D]   = req_i.timer_d;
        set_one[IFSR_B1_CAPCMP_C]  = req_i.capcmp_c;
        set_one[IFSR_B1_EXT_ONE]   = req_i.ext_pin_one;
        set_one[IFSR_B1_PIN_CHG]   = req_i.pin_change;
        set_one[IFSR_B1_COMPARE]   = req_i.comparator;
        set_one[IFSR_B1_SYNC_COL]  = req_i.sync_port_a_collision;
        set_one[IFSR_B1_SYNC_EVT]  = req_i.sync_port_a_event;
    end

    // Address phase accepted when selected, ready and NONSEQ or SEQ
    assign access   = hsel_i && hready_i && (htrans_i == IFSR_HTRANS_NONSEQ || htrans_i == IFSR_HTRANS_SEQ);
    assign addr_ofs = 12'(haddr_i);

    // Next state: data-phase write first, then hardware sets on top so a set always wins
    always_comb begin
        st_d = st_q;
        case (st_q.wr_kind)
            IFSR_WR_FLG0: st_d.flags_zero = hwdata_i[15:0];
            IFSR_WR_FLG1: st_d.flags_one  = hwdata_i[15:0];
            IFSR_WR_MSK0: st_d.mask_zero  = hwdata_i[15:0];
            IFSR_WR_MSK1: st_d.mask_one   = hwdata_i[15:0];
            IFSR_WR_CLR0: st_d.flags_zero = st_q.flags_zero & ~hwdata_i[15:0];
            IFSR_WR_CLR1: st_d.flags_one  = st_q.flags_one & ~hwdata_i[15:0];
            IFSR_WR_NONE: st_d.flags_zero = st_q.flags_zero;
            default:      st_d.flags_zero = st_q.flags_zero;
        endcase
        st_d.flags_zero = (st_d.flags_zero | set_zero) & IFSR_IMPL_ZERO;
        st_d.flags_one  = (st_d.flags_one | set_one) & IMPL_ONE;
        st_d.mask_zero  = st_d.mask_zero & IFSR_IMPL_ZERO;
        st_d.mask_one   = st_d.mask_one & IMPL_ONE;
        // Level interrupt tracks the registered flags and masks together
        st_d.irq        = |((st_d.flags_zero & st_d.mask_zero) | (st_d.flags_one & st_d.mask_one));
        // Latch write target; a read samples the post-write value so back-to-back traffic is coherent
        st_d.wr_kind    = IFSR_WR_NONE;
        if (access && hwrite_i) begin
            case (addr_ofs)
                IFSR_OFS_FLAGS_ZERO: st_d.wr_kind = IFSR_WR_FLG0;
                IFSR_OFS_FLAGS_ONE:  st_d.wr_kind = IFSR_WR_FLG1;
                IFSR_OFS_MASK_ZERO:  st_d.wr_kind = IFSR_WR_MSK0;
                IFSR_OFS_MASK_ONE:   st_d.wr_kind = IFSR_WR_MSK1;
                IFSR_OFS_CLR_ZERO:   st_d.wr_kind = IFSR_WR_CLR0;
                IFSR_OFS_CLR_ONE:    st_d.wr_kind = IFSR_WR_CLR1;
                default:             st_d.wr_kind = IFSR_WR_NONE;
            endcase
        end
        if (access && !hwrite_i) begin
            case (addr_ofs)
                IFSR_OFS_FLAGS_ZERO: st_d.hrdata = {16'h0000, st_d.flags_zero};
                IFSR_OFS_FLAGS_ONE:  st_d.hrdata = {16'h0000, st_d.flags_one};
                IFSR_OFS_MASK_ZERO:  st_d.hrdata = {16'h0000, st_d.mask_zero};
                IFSR_OFS_MASK_ONE:   st_d.hrdata = {16'h0000, st_d.mask_one};
                default:             st_d.hrdata = IFSR_RDATA_RST;
            endcase
        end
    end

    // Single state register; no wait states are ever inserted
    always_ff @(posedge mclk_i or posedge rst_i) begin
        if (rst_i) begin
            st_q.flags_zero <= IFSR_FLAGS_RST;
            st_q.flags_one  <= IFSR_FLAGS_RST;
            st_q.mask_zero  <= IFSR_MASK_RST;
            st_q.mask_one   <= IFSR_MASK_RST;
            st_q.wr_kind    <= IFSR_WR_NONE;
            st_q.hrdata     <= IFSR_RDATA_RST;
            st_q.irq        <= 1'b0;
        end else begin
            st_q <= st_d;
        end
    end

    // Ready and response are constant flops so every output is registered
    always_ff @(posedge mclk_i or posedge rst_i) begin
        if (rst_i) begin
            hreadyout_o <= 1'b1;
            hresp_o     <= IFSR_HRESP_OKAY;
        end else begin
            hreadyout_o <= 1'b1;
            hresp_o     <= IFSR_HRESP_OKAY;
        end
    end

    assign hrdata_o     = st_q.hrdata;
    assign flags_zero_o = st_q.flags_zero;
    assign flags_one_o  = st_q.flags_one;
    assign irq_o        = st_q.irq;

    // Masks seen by the checks; declared ahead of the first property that reads them
    logic [15:0] mask_zero_w;
    logic [15:0] mask_one_w;
    assign mask_zero_w = st_q.mask_zero;
    assign mask_one_w  = st_q.mask_one;

    // Checks
    default clocking ast_cb @(posedge mclk_i); endclocking
    default disable iff (rst_i);

    AST_SET_ZERO: assert property (req_i.nvm_op |=> flags_zero_o[IFSR_B0_NVM_OP])
        else $error("memory request did not set flag");
    AST_SET_ADC: assert property (req_i.adc_done |=> flags_zero_o[IFSR_B0_ADC_DONE])
        else $error("conversion request did not set flag");
    AST_SET_EXT0: assert property (req_i.ext_pin_zero |=> flags_zero_o[IFSR_B0_EXT_ZERO])
        else $error("pin zero request did not set flag");
    AST_SET_SYNC: assert property (req_i.sync_port_a_event |=> flags_one_o[IFSR_B1_SYNC_EVT])
        else $error("sync event did not set flag");
    AST_SET_CMP: assert property (req_i.comparator |=> flags_one_o[IFSR_B1_COMPARE])
        else $error("comparator request did not set flag");
    AST_UNIMPL: assert property ((flags_zero_o & ~IFSR_IMPL_ZERO) == 16'h0000
                                 && (flags_one_o & ~IMPL_ONE) == 16'h0000)
        else $error("unimplemented flag bit set");
    AST_HOLD: assert property (!(|set_zero) && st_q.wr_kind == IFSR_WR_NONE |=> $stable(flags_zero_o))
        else $error("flag changed without cause");
    AST_WRITE: assert property (st_q.wr_kind == IFSR_WR_FLG1 && !(|set_one)
                                |=> flags_one_o == ($past(hwdata_i[15:0]) & IMPL_ONE))
        else $error("flag write not stored");
    AST_IRQ: assert property (irq_o == |((flags_zero_o & mask_zero_w) | (flags_one_o & mask_one_w)))
        else $error("interrupt level wrong");
    AST_READY: assert property (hreadyout_o && hresp_o == IFSR_HRESP_OKAY)
        else $error("slave not ready or not okay");

    // Every remaining register zero source lands on its own bit one edge after its pulse
    AST_SET_TXA: assert property (req_i.serial_a_tx |=> flags_zero_o[IFSR_B0_SER_A_TX])
        else $error("serial A transmit request did not set flag");
    AST_SET_RXA: assert property (req_i.serial_a_rx |=> flags_zero_o[IFSR_B0_SER_A_RX])
        else $error("serial A receive request did not set flag");
    AST_SET_TMRC: assert property (req_i.timer_c |=> flags_zero_o[IFSR_B0_TIMER_C])
        else $error("timer C request did not set flag");
    AST_SET_TMRB: assert property (req_i.timer_b |=> flags_zero_o[IFSR_B0_TIMER_B])
        else $error("timer B request did not set flag");
    AST_SET_TMRA: assert property (req_i.timer_a |=> flags_zero_o[IFSR_B0_TIMER_A])
        else $error("timer A request did not set flag");
    AST_SET_CCPB: assert property (req_i.capcmp_b |=> flags_zero_o[IFSR_B0_CAPCMP_B])
        else $error("unit B request did not set flag");
    AST_SET_CCPA: assert property (req_i.capcmp_a |=> flags_zero_o[IFSR_B0_CAPCMP_A])
        else $error("unit A request did not set flag");

    // Register one sources; on the small variant the missing ones must stay clear
    AST_SET_TXB: assert property (req_i.serial_b_tx |=> flags_one_o[IFSR_B1_SER_B_TX] == LARGE_VARIANT)
        else $error("serial B transmit flag wrong");
    AST_SET_RXB: assert property (req_i.serial_b_rx |=> flags_one_o[IFSR_B1_SER_B_RX] == LARGE_VARIANT)
        else $error("serial B receive flag wrong");
    AST_SET_TMRD: assert property (req_i.timer_d |=> flags_one_o[IFSR_B1_TIMER_D] == LARGE_VARIANT)
        else $error("timer D flag wrong");
    AST_SET_CCPC: assert property (req_i.capcmp_c |=> flags_one_o[IFSR_B1_CAPCMP_C] == LARGE_VARIANT)
        else $error("unit C flag wrong");
    AST_SET_EXT2: assert property (req_i.ext_pin_two |=> flags_one_o[IFSR_B1_EXT_TWO])
        else $error("pin two request did not set flag");
    AST_SET_EXT1: assert property (req_i.ext_pin_one |=> flags_one_o[IFSR_B1_EXT_ONE])
        else $error("pin one request did not set flag");
    AST_SET_PCHG: assert property (req_i.pin_change |=> flags_one_o[IFSR_B1_PIN_CHG])
        else $error("pin change request did not set flag");
    AST_SET_COL: assert property (req_i.sync_port_a_collision |=> flags_one_o[IFSR_B1_SYNC_COL])
        else $error("sync collision request did not set flag");

    // Write-one-to-clear drops exactly the written ones when no request races it
    AST_CLR0: assert property (st_q.wr_kind == IFSR_WR_CLR0 && !(|set_zero)
                               |=> flags_zero_o == ($past(flags_zero_o) & ~$past(hwdata_i[15:0])))
        else $error("flag clear not applied");
    // Masks never keep a bit that has no flag behind it
    AST_MASK_IMPL: assert property ((mask_zero_w & ~IFSR_IMPL_ZERO) == 16'h0000
                                    && (mask_one_w & ~IMPL_ONE) == 16'h0000)
        else $error("mask bit kept at unimplemented position");
    // Upper half of every register word reads zero
    AST_RD_HIGH: assert property (hrdata_o[31:16] == 16'h0000)
        else $error("read data upper half not zero");

    COV_WR_ONE: cover property (st_q.wr_kind == IFSR_WR_FLG1);
    COV_REQ_IRQ: cover property (req_i.timer_a ##1 irq_o);
    COV_CLR_RACE: cover property (st_q.wr_kind == IFSR_WR_CLR0 && set_zero[IFSR_B0_TIMER_A]);
    COV_READ: cover property (access && !hwrite_i && addr_ofs == IFSR_OFS_FLAGS_ONE);

endmodule : ifsr_top

// ===== tb_interrupt_flag_status_regs.sv
`timescale 1ns/1ps
module tb_interrupt_flag_status_regs;
    import ifsr_pkg::*;
    logic mclk_i = 1'b0, rst_i = 1'b1, hsel = 1'b0, hwrite = 1'b0, hready, hresp, irq, irq_s;
    logic [11:0] haddr = 12'h000;
    logic [1:0]  htrans = 2'h0;
    logic [31:0] hwdata = 32'h0, hrdata, rd;
    logic [15:0] fl0, fl1, fl1_s;
    ifsr_req_t   fire = '0, req;
    int          err_total = 0, compares = 0;
    // Bit positions of each source, in request struct order: register zero then register one
    int          pos [20] = '{15, 13, 12, 11, 8, 7, 6, 3, 2, 0, 15, 14, 13, 11, 9, 4, 3, 2, 1, 0};

    always #5 mclk_i = ~mclk_i;

    ifsr_periph_model periph (.mclk_i(mclk_i), .rst_i(rst_i), .fire_i(fire), .req_o(req));
    ifsr_top dut (.mclk_i(mclk_i), .rst_i(rst_i), .hsel_i(hsel), .haddr_i(haddr), .htrans_i(htrans),
        .hwrite_i(hwrite), .hsize_i(3'h2), .hwdata_i(hwdata), .hready_i(hready), .req_i(req),
        .hrdata_o(hrdata), .hreadyout_o(hready), .hresp_o(hresp), .flags_zero_o(fl0),
        .flags_one_o(fl1), .irq_o(irq));
    // Small variant shares the bus and requests; only its register one flag output is judged
    ifsr_top #(.LARGE_VARIANT(1'b0)) dut_small (.mclk_i(mclk_i), .rst_i(rst_i), .hsel_i(hsel),
        .haddr_i(haddr), .htrans_i(htrans), .hwrite_i(hwrite), .hsize_i(3'h2), .hwdata_i(hwdata),
        .hready_i(hready), .req_i(req), .hrdata_o(), .hreadyout_o(), .hresp_o(), .flags_zero_o(),
        .flags_one_o(fl1_s), .irq_o(irq_s));

    task automatic check_word(input logic [31:0] got, input logic [31:0] exp);
        compares++;
        if (got !== exp) begin
            err_total++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : check_word

    task automatic check_bit(input logic got, input logic exp);
        check_word({31'h0, got}, {31'h0, exp});
    endtask : check_bit

    // Wait for ready at a rising edge, bounded so a stuck slave cannot hang the run
    task automatic wait_ready();
        int n;
        n = 0;
        do begin
            @(posedge mclk_i);
            n++;
        end while (hready !== 1'b1 && n < 50);
        if (n >= 50) check_bit(1'b0, 1'b1);
    endtask : wait_ready

    // One AHB-Lite single transfer; f lets requests land in the data phase
    task automatic bus(input logic wr, input logic [11:0] a, input logic [31:0] d, input ifsr_req_t f);
        hsel <= 1'b1; haddr <= a; htrans <= IFSR_HTRANS_NONSEQ; hwrite <= wr; fire <= f;
        wait_ready();
        hsel <= 1'b0; htrans <= 2'h0; hwdata <= d; fire <= '0;
        wait_ready();
        rd = hrdata;
        check_bit(hresp, IFSR_HRESP_OKAY);
        @(posedge mclk_i); // Idle edge so callers see the data-phase update
    endtask : bus

    task automatic test_reset();
        bus(1'b0, IFSR_OFS_FLAGS_ZERO, 32'h0, '0); check_word(rd, 32'h0);
        bus(1'b0, IFSR_OFS_FLAGS_ONE, 32'h0, '0); check_word(rd, 32'h0);
        bus(1'b0, 12'h100, 32'h0, '0); check_word(rd, 32'h0);
        $display("test reset done");
    endtask : test_reset

    task automatic test_rw();
        bus(1'b1, IFSR_OFS_FLAGS_ZERO, 32'hffff_ffff, '0);
        bus(1'b1, IFSR_OFS_FLAGS_ONE, 32'hffff_ffff, '0);
        bus(1'b0, IFSR_OFS_FLAGS_ZERO, 32'h0, '0); check_word(rd, 32'h0000_b9cd);
        bus(1'b0, IFSR_OFS_FLAGS_ONE, 32'h0, '0); check_word(rd, 32'h0000_ea1f);
        check_word({16'h0, fl1_s}, 32'h0000_201f);
        bus(1'b1, IFSR_OFS_FLAGS_ZERO, 32'h0, '0);
        bus(1'b1, IFSR_OFS_FLAGS_ONE, 32'h0, '0);
        bus(1'b0, IFSR_OFS_FLAGS_ONE, 32'h0, '0); check_word(rd, 32'h0);
        $display("test rw done");
    endtask : test_rw

    // Pulse every source alone and see exactly its own bit rise
    task automatic test_sources();
        logic [15:0] e0, e1;
        for (int i = 0; i < 20; i++) begin
            e0 = (i < 10) ? 16'h1 << pos[i] : 16'h0;
            e1 = (i >= 10) ? 16'h1 << pos[i] : 16'h0;
            bus(1'b0, 12'h100, 32'h0, ifsr_req_t'(20'h80000 >> i));
            bus(1'b0, IFSR_OFS_FLAGS_ZERO, 32'h0, '0); check_word(rd, {16'h0, e0});
            bus(1'b0, IFSR_OFS_FLAGS_ONE, 32'h0, '0); check_word(rd, {16'h0, e1});
            check_word({16'h0, fl1_s}, {16'h0, e1 & 16'h201f});
            check_bit(irq, 1'b0);
            bus(1'b1, IFSR_OFS_FLAGS_ZERO, 32'h0, '0);
            bus(1'b1, IFSR_OFS_FLAGS_ONE, 32'h0, '0);
        end
        $display("test sources done");
    endtask : test_sources

    task automatic test_irq();
        bus(1'b1, IFSR_OFS_MASK_ZERO, 32'h0000_0001, '0);
        bus(1'b0, 12'h100, 32'h0, ifsr_req_t'(20'h00400));
        check_bit(irq, 1'b1);
        bus(1'b1, IFSR_OFS_MASK_ZERO, 32'h0, '0); check_bit(irq, 1'b0);
        bus(1'b1, IFSR_OFS_MASK_ZERO, 32'h0000_0001, '0); check_bit(irq, 1'b1);
        bus(1'b1, IFSR_OFS_CLR_ZERO, 32'h0000_0001, '0); check_bit(irq, 1'b0);
        check_word({16'h0, fl0}, 32'h0);
        $display("test irq done");
    endtask : test_irq

    // Timer A request lands in the data phase of a software write of zero
    task automatic test_race();
        bus(1'b1, IFSR_OFS_FLAGS_ZERO, 32'h0, ifsr_req_t'(20'h01000));
        bus(1'b0, IFSR_OFS_FLAGS_ZERO, 32'h0, '0); check_word(rd, 32'h0000_0008);
        bus(1'b1, IFSR_OFS_CLR_ZERO, 32'h0000_0008, ifsr_req_t'(20'h01000));
        check_word({16'h0, fl0}, 32'h0000_0008);
        $display("test race done");
    endtask : test_race

    // Reset in mid-run wipes flags, masks and the interrupt
    task automatic test_midreset();
        bus(1'b1, IFSR_OFS_FLAGS_ONE, 32'h0000_ffff, '0);
        bus(1'b1, IFSR_OFS_MASK_ONE, 32'h0000_ffff, '0); check_bit(irq, 1'b1);
        rst_i <= 1'b1;
        repeat (2) @(posedge mclk_i);
        rst_i <= 1'b0;
        @(posedge mclk_i);
        check_word({16'h0, fl1}, 32'h0);
        check_bit(irq, 1'b0);
        bus(1'b0, IFSR_OFS_MASK_ONE, 32'h0, '0); check_word(rd, 32'h0);
        $display("test midreset done");
    endtask : test_midreset

    task automatic summarize();
        $display("comparisons %0d mismatches %0d", compares, err_total);
        if (err_total == 0 && compares > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask : summarize

    initial begin
        repeat (10) @(posedge mclk_i);
        rst_i <= 1'b0;
        test_reset();
        test_rw();
        test_sources();
        test_irq();
        test_race();
        test_midreset();
        summarize();
    end

    // Watchdog: the tests need well under 2000 cycles
    initial begin
        #200us;
        err_total++;
        summarize();
    end
endmodule : tb_interrupt_flag_status_regs
